/* File: logic/asp_pkg.sv */
// package for the analog set-point and enable register bank
// assumes a 32-bit APB slave, registers one per aligned word
package asp_pkg;
	localparam int ADDR_W = 12;
	// printed offsets are word indices, byte address is four times the index
	localparam logic [8:0] IDX_CSET1 = 9'h08F;
	localparam logic [8:0] IDX_CSET2 = 9'h090;
	localparam logic [8:0] IDX_VSET1 = 9'h091;
	localparam logic [8:0] IDX_VSET2 = 9'h092;
	localparam logic [8:0] IDX_PE = 9'h107;
	localparam logic [8:0] IDX_ABE1 = 9'h10C;
	localparam logic [ADDR_W-1:0] ADDR_CSET1 = {1'b0, IDX_CSET1, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_CSET2 = {1'b0, IDX_CSET2, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_VSET1 = {1'b0, IDX_VSET1, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_VSET2 = {1'b0, IDX_VSET2, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_PE = {1'b0, IDX_PE, 2'b00};
	localparam logic [ADDR_W-1:0] ADDR_ABE1 = {1'b0, IDX_ABE1, 2'b00};
	// reset values and writable bits
	localparam logic [7:0] SETPT_RST = 8'h00;
	localparam logic [7:0] PE_RST = 8'h0C;
	localparam logic [7:0] PE_WMASK = 8'hCF;
	localparam logic [7:0] ABE_RST = 8'h00;
	// converter scale: millivolts = full scale * code / 2^CODE_BITS
	localparam int CODE_BITS = 8;
	localparam logic [18:0] VSET_FS_MV = 19'h00800;
	localparam logic [18:0] CSET_FS_MV = 19'h00400;
	localparam int VMV_W = 11;
	localparam int CMV_W = 10;
	localparam int CHS_W = 5;

	typedef struct packed {
		logic gateDriveEnableCh1;
		logic gateDriveEnableCh2;
		logic [1:0] unused;
		logic sensePullupEnableCh1;
		logic sensePullupEnableCh2;
		logic regulatorSleepLevelSel;
		logic regulatorLowPowerEnable;
	} asp_pe_t;

	typedef struct packed {
		logic digitalTestOutEnable;
		logic auxAmpGainSel;
		logic [1:0] digitalTestChannelSel;
		logic driverUvloLevelSel;
		logic currentAmpDisableCh1;
		logic voltageAmpDisableCh1;
		logic analogTestOutEnable;
	} asp_abe_t;

	typedef struct packed {
		logic [1:0][7:0] vSet;
		logic [1:0][7:0] cSet;
		asp_pe_t pe;
		asp_abe_t abe;
		logic [1:0][VMV_W-1:0] vMv;
		logic [1:0][CMV_W-1:0] cMv;
		logic [CHS_W-1:0] anaSel;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} asp_state_t;
endpackage

/* File: logic/asp_setpoint_regs.sv */
// register bank: four set-point converters, peripheral enables, analog block control
// assumes an APB master on ref_clk and a synchronous converter channel select input
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - voltage set point in mV equals 2048 times code over 256.
// - current set point in mV equals 1024 times code over 256.
// - four set-point registers are read/write, eight bits, reset to zero.
// - enable bits 7 and 6 turn on channel one and two gate drivers.
// - enable bits 3 and 2 turn on sense pull-ups, reset to one.
// - enable bit 1 picks sleep regulator level, 5V set, 3V clear.
// - enable bit 0 puts regulator in low-power mode, resets to zero.
// - enable bits 5 and 4 ignore writes and read zero.
// - control bit 7 routes digital test output onto pin three.
// - control bit 6 selects auxiliary amplifier gain two or one.
// - control bits 5 to 4 select digital test channel.
// - control bit 3 selects gate-drive lockout 5.4V or 2.7V.
// - control bit 2 disables channel one current error amplifier.
// - control bit 1 disables channel one voltage error amplifier.
// - control bit 0 connects analog test output to pin zero.
// - while analog output enabled, channel select picks signal on pin zero.
// - every control register bit is read/write and resets to zero.
// - analog channel select comes from converter control five-bit field.
module asp_setpoint_regs (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [asp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// converter control channel select field
	input wire logic [asp_pkg::CHS_W-1:0] convChanSel,
	// analog controls
	output asp_pkg::asp_pe_t peCtrl,
	output asp_pkg::asp_abe_t abeCtrl,
	output logic [asp_pkg::CHS_W-1:0] analogChannelSel,
	output logic [asp_pkg::VMV_W-1:0] voltSetMvCh1,
	output logic [asp_pkg::VMV_W-1:0] voltSetMvCh2,
	output logic [asp_pkg::CMV_W-1:0] currSetMvCh1,
	output logic [asp_pkg::CMV_W-1:0] currSetMvCh2
);
	asp_pkg::asp_state_t st_r;
	asp_pkg::asp_state_t st_nxt;
	logic accStart;
	logic accDone;
	logic hit;
	logic wrEn;
	logic [7:0] rdByte;
	logic [18:0] vProd [2];
	logic [18:0] cProd [2];

	// one wait state: pready rises in the second access cycle
	assign accStart = psel && penable && !st_r.pready;
	assign accDone = psel && penable && st_r.pready;

	always_comb begin
		hit = 1'b1;
		rdByte = 8'h00;
		unique case (paddr)
			asp_pkg::ADDR_CSET1: rdByte = st_r.cSet[0];
			asp_pkg::ADDR_CSET2: rdByte = st_r.cSet[1];
			asp_pkg::ADDR_VSET1: rdByte = st_r.vSet[0];
			asp_pkg::ADDR_VSET2: rdByte = st_r.vSet[1];
			asp_pkg::ADDR_PE: rdByte = st_r.pe;
			asp_pkg::ADDR_ABE1: rdByte = st_r.abe;
			default: hit = 1'b0;
		endcase
	end

	// write lands only at the completing edge, low byte lane only
	assign wrEn = accDone && pwrite && hit && pstrb[0];

	always_comb begin
		st_nxt = st_r;
		st_nxt.pready = accStart;
		st_nxt.pslverr = accStart && !hit;
		st_nxt.prdata = 32'h0000_0000;
		if (accStart && !pwrite) begin
			st_nxt.prdata = {24'h00_0000, rdByte};
		end
		if (wrEn) begin
			unique case (paddr)
				asp_pkg::ADDR_CSET1: st_nxt.cSet[0] = pwdata[7:0];
				asp_pkg::ADDR_CSET2: st_nxt.cSet[1] = pwdata[7:0];
				asp_pkg::ADDR_VSET1: st_nxt.vSet[0] = pwdata[7:0];
				asp_pkg::ADDR_VSET2: st_nxt.vSet[1] = pwdata[7:0];
				// unimplemented enable bits stay zero
				asp_pkg::ADDR_PE: st_nxt.pe = pwdata[7:0] & asp_pkg::PE_WMASK;
				asp_pkg::ADDR_ABE1: st_nxt.abe = pwdata[7:0];
				default: st_nxt.abe = st_r.abe;
			endcase
		end
		// converters track the new code on the same edge as the write
		for (int i = 0; i < 2; i++) begin
			vProd[i] = {11'h000, st_nxt.vSet[i]} * asp_pkg::VSET_FS_MV;
			cProd[i] = {11'h000, st_nxt.cSet[i]} * asp_pkg::CSET_FS_MV;
			st_nxt.vMv[i] = vProd[i][asp_pkg::CODE_BITS +: asp_pkg::VMV_W];
			st_nxt.cMv[i] = cProd[i][asp_pkg::CODE_BITS +: asp_pkg::CMV_W];
		end
		// pin zero sees no selection while the analog output is off
		st_nxt.anaSel = st_nxt.abe.analogTestOutEnable ? convChanSel : '0;
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r.vSet <= {asp_pkg::SETPT_RST, asp_pkg::SETPT_RST};
			st_r.cSet <= {asp_pkg::SETPT_RST, asp_pkg::SETPT_RST};
			st_r.pe <= asp_pkg::PE_RST;
			st_r.abe <= asp_pkg::ABE_RST;
			st_r.vMv <= '0;
			st_r.cMv <= '0;
			st_r.anaSel <= '0;
			st_r.pready <= 1'b0;
			st_r.pslverr <= 1'b0;
			st_r.prdata <= 32'h0000_0000;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;
	assign prdata = st_r.prdata;
	assign peCtrl = st_r.pe;
	assign abeCtrl = st_r.abe;
	assign analogChannelSel = st_r.anaSel;
	assign voltSetMvCh1 = st_r.vMv[0];
	assign voltSetMvCh2 = st_r.vMv[1];
	assign currSetMvCh1 = st_r.cMv[0];
	assign currSetMvCh2 = st_r.cMv[1];

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	sequence wrCompl(logic [asp_pkg::ADDR_W-1:0] a);
		psel && penable && pready && pwrite && pstrb[0] && paddr == a;
	endsequence

	sequence accWait;
		psel && penable && !pready ##1 pready;
	endsequence

	volt_scale_a: assert property (voltSetMvCh1 == {st_r.vSet[0], 3'b000})
		else $error("voltage set point not 2048*code/256");
	curr_scale_a: assert property (currSetMvCh2 == {st_r.cSet[1], 2'b00})
		else $error("current set point not 1024*code/256");
	setpt_write_a: assert property (wrCompl(asp_pkg::ADDR_VSET1) |=>
		st_r.vSet[0] == $past(pwdata[7:0]) && voltSetMvCh1 == {$past(pwdata[7:0]), 3'b000})
		else $error("voltage code or converter not updated by write");
	// a sequence cannot be negated as a boolean, so the write is spelled out here
	cset_hold_a: assert property (!(psel && penable && pready && pwrite && pstrb[0]
		&& paddr == asp_pkg::ADDR_CSET1) |=> $stable(st_r.cSet[0]))
		else $error("current code changed without a write");
	pe_write_a: assert property (wrCompl(asp_pkg::ADDR_PE) |=>
		peCtrl == ($past(pwdata[7:0]) & 8'hCF))
		else $error("peripheral enable write mismatch");
	pe_rsvd_a: assert property (peCtrl.unused == 2'b00)
		else $error("unimplemented enable bits nonzero");
	abe_write_a: assert property (wrCompl(asp_pkg::ADDR_ABE1) |=> abeCtrl == $past(pwdata[7:0]))
		else $error("analog control write mismatch");
	ana_sel_a: assert property (abeCtrl.analogTestOutEnable |->
		analogChannelSel == $past(convChanSel))
		else $error("analog channel select not followed");
	ana_off_a: assert property (!abeCtrl.analogTestOutEnable |-> analogChannelSel == '0)
		else $error("analog channel select while output off");
	apb_wait_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
		else $error("pready timing wrong");
	// read data stands only in the pready cycle, so it is checked there
	rd_data_a: assert property ((psel && !pwrite && paddr == asp_pkg::ADDR_PE) ##0 accWait
		|-> prdata == {24'h00_0000, $past(st_r.pe)})
		else $error("read data of enable register wrong");
	unmap_err_a: assert property (psel && penable && !pready && !hit |=> pslverr && pready)
		else $error("unmapped access not flagged");
endmodule

`default_nettype wire

/* File: dv/tb.sv */
// bench for the set-point register bank: apb traffic checked against a bench model
// assumes the bank is the only apb slave and convChanSel may change every cycle
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [asp_pkg::ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = '0;
	logic [asp_pkg::CHS_W-1:0] convChanSel = '0;
	logic [asp_pkg::CHS_W-1:0] convPrev = '0;
	logic pready, pslverr;
	logic [31:0] prdata, rd;
	asp_pkg::asp_pe_t peCtrl;
	asp_pkg::asp_abe_t abeCtrl;
	logic [asp_pkg::CHS_W-1:0] analogChannelSel;
	logic [asp_pkg::VMV_W-1:0] voltSetMvCh1, voltSetMvCh2;
	logic [asp_pkg::CMV_W-1:0] currSetMvCh1, currSetMvCh2;
	logic [7:0] mdl [6];
	logic [asp_pkg::ADDR_W-1:0] adr [6];
	logic er;
	int failures = 0;
	int checks_done = 0;
	int k;

	asp_setpoint_regs asp_setpoint_regs_inst (.ref_clk, .reset_n, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata, .convChanSel, .peCtrl, .abeCtrl,
		.analogChannelSel, .voltSetMvCh1, .voltSetMvCh2, .currSetMvCh1, .currSetMvCh2);

	initial begin
		forever #50 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
		apb(1'b1, adr[i], d, s);
		if (s[0]) mdl[i] = d[7:0] & ((i == 4) ? asp_pkg::PE_WMASK : 8'hFF);
		chk({31'h0, er}, 32'h0);
	endtask

	task automatic rd_reg(input int i);
		apb(1'b0, adr[i], 32'h0, 4'h0);
		chk(rd, {24'h0, mdl[i]});
		chk({31'h0, er}, 32'h0);
	endtask

	task automatic do_reset();
		@(posedge ref_clk);
		reset_n <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			mdl[i] = (i == 4) ? asp_pkg::PE_RST : (i == 5) ? asp_pkg::ABE_RST : asp_pkg::SETPT_RST;
		end
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
	endtask

	always @(posedge ref_clk) begin
		convPrev <= convChanSel;
		convChanSel <= 5'($urandom);
	end

	// outputs compared every cycle, so a late or missed update shows at once
	always @(negedge ref_clk) begin
		chk({21'h0, voltSetMvCh1}, {21'h0, mdl[2], 3'h0});
		chk({21'h0, voltSetMvCh2}, {21'h0, mdl[3], 3'h0});
		chk({22'h0, currSetMvCh1}, {22'h0, mdl[0], 2'h0});
		chk({22'h0, currSetMvCh2}, {22'h0, mdl[1], 2'h0});
		chk({24'h0, peCtrl}, {24'h0, mdl[4]});
		chk({24'h0, abeCtrl}, {24'h0, mdl[5]});
		chk({27'h0, analogChannelSel}, {27'h0, mdl[5][0] ? convPrev : 5'h0});
	end

	initial begin
		#(20000 * 100);
		failures++;
		report_and_stop();
	end

	initial begin
		adr = '{asp_pkg::ADDR_CSET1, asp_pkg::ADDR_CSET2, asp_pkg::ADDR_VSET1,
			asp_pkg::ADDR_VSET2, asp_pkg::ADDR_PE, asp_pkg::ADDR_ABE1};
		k = $urandom(51);
		do_reset();
		for (int i = 0; i < 6; i++) rd_reg(i);
		for (int i = 0; i < 6; i++) wr_reg(i, 32'hFFFF_FFFF, 4'hF);
		for (int i = 0; i < 6; i++) rd_reg(i);
		repeat (80) begin
			wr_reg($urandom_range(5), $urandom, 4'($urandom));
			rd_reg($urandom_range(5));
		end
		// unmapped and unaligned places refuse and change nothing
		apb(1'b1, 12'h000, 32'h0000_00A5, 4'hF);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, asp_pkg::ADDR_PE + 12'h002, 32'h0000_0030, 4'hF);
		chk({31'h0, er}, 32'h1);
		apb(1'b0, asp_pkg::ADDR_VSET1 + 12'h001, 32'h0, 4'h0);
		chk(rd, 32'h0);
		chk({31'h0, er}, 32'h1);
		for (int i = 0; i < 6; i++) rd_reg(i);
		do_reset();
		for (int i = 0; i < 6; i++) rd_reg(i);
		report_and_stop();
	end
endmodule
`default_nettype wire
